// File: shared/cdt_pkg.sv
// shared constants, register map and state type of the cascadable down-timer block
package cdt_pkg;
   // ----------------------------------------------------------------
   // register byte offsets (one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00; // enables, reload modes, cascade
   localparam logic [7:0] A_LOW_RLD_OFF = 8'h04; // pair a low reload value
   localparam logic [7:0] A_LOW_CNT_OFF = 8'h08; // pair a low present count
   localparam logic [7:0] A_HIGH_RLD_OFF = 8'h0C; // pair a high reload value
   localparam logic [7:0] A_HIGH_CNT_OFF = 8'h10; // pair a high present count
   localparam logic [7:0] B_LOW_RLD_OFF = 8'h14; // pair b low reload value
   localparam logic [7:0] B_LOW_CNT_OFF = 8'h18; // pair b low present count
   localparam logic [7:0] B_HIGH_RLD_OFF = 8'h1C; // pair b high reload value
   localparam logic [7:0] B_HIGH_CNT_OFF = 8'h20; // pair b high present count
   localparam logic [7:0] STAT_OFF = 8'h24; // read-only run and pwm state
   // ----------------------------------------------------------------
   // control field positions
   // ----------------------------------------------------------------
   localparam int EN_LSB = 0; // three enables: a low, a high, b wide
   localparam int RL_LSB = 4; // three reload modes, same order
   localparam int CASC_BIT = 8; // chain pair a into one 16-bit pwm timer
   // ----------------------------------------------------------------
   // counter indices inside the state
   // ----------------------------------------------------------------
   localparam int A_LO = 0;
   localparam int A_HI = 1;
   localparam int B_LO = 2;
   localparam int B_HI = 3;
   // ----------------------------------------------------------------
   // whole state of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0][7:0] cnt; // present counts
      logic [3:0][7:0] rld; // reload values
      logic [2:0] en; // run enables
      logic [2:0] rl; // reload (1) or single-shot (0)
      logic casc; // pair a cascaded
      logic pwm; // pwm level of cascaded pair a
      logic [2:0] zero; // zero-reached pulses
      logic wpend; // write data phase pending
      logic [7:0] waddr; // address of pending write
      logic [31:0] rdata; // read data for the data phase
      logic rdy; // bus ready
   } cdt_state_t;
   localparam cdt_state_t RST_STATE = '{rdy: 1'b1, default: '0};
endpackage

// File: rtl/cdt_timers.sv
// four 8-bit down timers, pair a splittable or pwm-cascaded, pair b wide, on ahb-lite
//
// Functional notes
// - pair a runs as two independent timers
// - pair a cascades into 16-bit pwm timer
// - pair b works only as 16-bit timer
// - pair b: high counter msb, low lsb
// - pair a cascade: high msb, low lsb
// - each timer: readable/writable reload and count
// - enabled timer decrements until zero
// - zero raises event, optional reload copy
// - single-shot: stop and clear enable bit
// - reload mode keeps running from reload
// - registers writable at any time
// - count write: continue from new value
// - changed reload used at next zero
// - software write beats decrement write-back
// - hardware enable clear beats software write
// - reads never disturb timer operation
`timescale 1ns/100ps
module cdt_timers
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic zero_a_low,
   output logic zero_a_high,
   output logic zero_b_wide,
   output logic pwm_out
);
   // ----------------------------------------------------------------
   // state and next state
   // ----------------------------------------------------------------
   cdt_pkg::cdt_state_t s_r; // registered state
   cdt_pkg::cdt_state_t s_nxt; // next state
   logic take; // address phase accepted this edge
   logic [15:0] a_wide; // pair a as one count
   logic [15:0] b_wide; // pair b as one count

   assign take = hsel && htrans[1] && hready;
   assign a_wide = {s_r.cnt[cdt_pkg::A_HI], s_r.cnt[cdt_pkg::A_LO]};
   assign b_wide = {s_r.cnt[cdt_pkg::B_HI], s_r.cnt[cdt_pkg::B_LO]};

   // outputs straight from the state flops, except hresp which is tied low
   assign hrdata = s_r.rdata;
   assign hreadyout = s_r.rdy;
   assign hresp = 1'b0;
   assign zero_a_low = s_r.zero[0];
   assign zero_a_high = s_r.zero[1];
   assign zero_b_wide = s_r.zero[2];
   assign pwm_out = s_r.pwm;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   // timers first, then the software write on top so that it wins everywhere but the single-shot enable clears
   always_comb
   begin
      logic [2:0] hwclr; // enables cleared by single-shot stops
      logic [15:0] w; // scratch wide count
      hwclr = 3'b000;
      w = 16'h0000;
      s_nxt = s_r;
      s_nxt.zero = 3'b000;
      s_nxt.rdy = 1'b1;
      if (!s_r.casc)
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (s_r.en[i])
            begin
               if (s_r.cnt[i] == 8'h00)
               begin
                  s_nxt.zero[i] = 1'b1;
                  if (s_r.rl[i])
                  begin
                     s_nxt.cnt[i] = s_r.rld[i];
                  end
                  else
                  begin
                     hwclr[i] = 1'b1;
                  end
               end
               else
               begin
                  s_nxt.cnt[i] = s_r.cnt[i] - 8'h01;
               end
            end
         end
      end
      else if (s_r.en[0])
      begin
         // cascaded pwm pair, high byte is msb
         if (a_wide == 16'h0000)
         begin
            s_nxt.zero[0] = 1'b1;
            s_nxt.pwm = !s_r.pwm;
            if (s_r.rl[0])
            begin
               s_nxt.cnt[cdt_pkg::A_HI] = s_r.rld[cdt_pkg::A_HI];
               s_nxt.cnt[cdt_pkg::A_LO] = s_r.rld[cdt_pkg::A_LO];
            end
            else
            begin
               hwclr[0] = 1'b1;
            end
         end
         else
         begin
            // wide subtract steps high only on low underflow
            w = a_wide - 16'h0001;
            s_nxt.cnt[cdt_pkg::A_HI] = w[15:8];
            s_nxt.cnt[cdt_pkg::A_LO] = w[7:0];
         end
      end
      if (s_r.en[2])
      begin
         if (b_wide == 16'h0000)
         begin
            s_nxt.zero[2] = 1'b1;
            if (s_r.rl[2])
            begin
               s_nxt.cnt[cdt_pkg::B_HI] = s_r.rld[cdt_pkg::B_HI];
               s_nxt.cnt[cdt_pkg::B_LO] = s_r.rld[cdt_pkg::B_LO];
            end
            else
            begin
               hwclr[2] = 1'b1;
            end
         end
         else
         begin
            w = b_wide - 16'h0001;
            s_nxt.cnt[cdt_pkg::B_HI] = w[15:8];
            s_nxt.cnt[cdt_pkg::B_LO] = w[7:0];
         end
      end
      s_nxt.en = s_r.en & ~hwclr;
      s_nxt.wpend = 1'b0;
      if (s_r.wpend)
      begin
         if (s_r.waddr == cdt_pkg::CTRL_OFF)
         begin
            // a hardware stop beats the written enable
            s_nxt.en = hwdata[cdt_pkg::EN_LSB +: 3] & ~hwclr;
            s_nxt.rl = hwdata[cdt_pkg::RL_LSB +: 3];
            s_nxt.casc = hwdata[cdt_pkg::CASC_BIT];
         end
         else if (s_r.waddr == cdt_pkg::A_LOW_RLD_OFF)
         begin
            s_nxt.rld[cdt_pkg::A_LO] = hwdata[7:0];
         end
         else if (s_r.waddr == cdt_pkg::A_HIGH_RLD_OFF)
         begin
            s_nxt.rld[cdt_pkg::A_HI] = hwdata[7:0];
         end
         else if (s_r.waddr == cdt_pkg::B_LOW_RLD_OFF)
         begin
            s_nxt.rld[cdt_pkg::B_LO] = hwdata[7:0];
         end
         else if (s_r.waddr == cdt_pkg::B_HIGH_RLD_OFF)
         begin
            s_nxt.rld[cdt_pkg::B_HI] = hwdata[7:0];
         end
         // count writes override the decrementer, run on from it
         else if (s_r.waddr == cdt_pkg::A_LOW_CNT_OFF)
         begin
            s_nxt.cnt[cdt_pkg::A_LO] = hwdata[7:0];
         end
         else if (s_r.waddr == cdt_pkg::A_HIGH_CNT_OFF)
         begin
            s_nxt.cnt[cdt_pkg::A_HI] = hwdata[7:0];
         end
         else if (s_r.waddr == cdt_pkg::B_LOW_CNT_OFF)
         begin
            s_nxt.cnt[cdt_pkg::B_LO] = hwdata[7:0];
         end
         else if (s_r.waddr == cdt_pkg::B_HIGH_CNT_OFF)
         begin
            s_nxt.cnt[cdt_pkg::B_HI] = hwdata[7:0];
         end
         // unmapped or read-only: write dropped, answer still okay
      end
      // address phase: writes wait a cycle for hwdata, reads load now
      if (take && hwrite)
      begin
         s_nxt.wpend = 1'b1;
         s_nxt.waddr = haddr[7:0];
      end
      else if (take)
      begin
         // reads never touch timers, every register reads back
         if (haddr[7:0] == cdt_pkg::CTRL_OFF)
         begin
            s_nxt.rdata = {23'h0, s_r.casc, 1'b0, s_r.rl, 1'b0, s_r.en};
         end
         else if (haddr[7:0] == cdt_pkg::A_LOW_RLD_OFF)
         begin
            s_nxt.rdata = {24'h000000, s_r.rld[cdt_pkg::A_LO]};
         end
         else if (haddr[7:0] == cdt_pkg::A_LOW_CNT_OFF)
         begin
            s_nxt.rdata = {24'h000000, s_r.cnt[cdt_pkg::A_LO]};
         end
         else if (haddr[7:0] == cdt_pkg::A_HIGH_RLD_OFF)
         begin
            s_nxt.rdata = {24'h000000, s_r.rld[cdt_pkg::A_HI]};
         end
         else if (haddr[7:0] == cdt_pkg::A_HIGH_CNT_OFF)
         begin
            s_nxt.rdata = {24'h000000, s_r.cnt[cdt_pkg::A_HI]};
         end
         else if (haddr[7:0] == cdt_pkg::B_LOW_RLD_OFF)
         begin
            s_nxt.rdata = {24'h000000, s_r.rld[cdt_pkg::B_LO]};
         end
         else if (haddr[7:0] == cdt_pkg::B_LOW_CNT_OFF)
         begin
            s_nxt.rdata = {24'h000000, s_r.cnt[cdt_pkg::B_LO]};
         end
         else if (haddr[7:0] == cdt_pkg::B_HIGH_RLD_OFF)
         begin
            s_nxt.rdata = {24'h000000, s_r.rld[cdt_pkg::B_HI]};
         end
         else if (haddr[7:0] == cdt_pkg::B_HIGH_CNT_OFF)
         begin
            s_nxt.rdata = {24'h000000, s_r.cnt[cdt_pkg::B_HI]};
         end
         else if (haddr[7:0] == cdt_pkg::STAT_OFF)
         begin
            s_nxt.rdata = {28'h0000000, s_r.pwm, s_r.en};
         end
         else
         begin
            // unmapped reads as zero
            s_nxt.rdata = 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r <= cdt_pkg::RST_STATE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // helpers: a pending write to a given count register or to ctrl
   logic wr_alo;
   logic wr_ahi;
   logic wr_b;
   logic wr_ctrl;
   assign wr_alo = s_r.wpend && (s_r.waddr == cdt_pkg::A_LOW_CNT_OFF);
   assign wr_ahi = s_r.wpend && (s_r.waddr == cdt_pkg::A_HIGH_CNT_OFF);
   assign wr_b = s_r.wpend && ((s_r.waddr == cdt_pkg::B_LOW_CNT_OFF)
                               || (s_r.waddr == cdt_pkg::B_HIGH_CNT_OFF));
   assign wr_ctrl = s_r.wpend && (s_r.waddr == cdt_pkg::CTRL_OFF);

   a_low_dec_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!s_r.casc && s_r.en[0] && s_r.cnt[0] != 8'h00 && !wr_alo && !wr_ctrl)
      |=> (s_r.cnt[0] == $past(s_r.cnt[0]) - 8'h01))
      else $error("pair a low count did not step down by one");
   a_low_reload_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!s_r.casc && s_r.en[0] && s_r.rl[0] && s_r.cnt[0] == 8'h00 && !wr_alo)
      |=> (s_r.cnt[0] == $past(s_r.rld[0])) && s_r.zero[0])
      else $error("pair a low did not reload at zero");
   oneshot_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!s_r.casc && s_r.en[0] && !s_r.rl[0] && s_r.cnt[0] == 8'h00 && !wr_alo)
      |=> !s_r.en[0] ##1 (s_r.cnt[0] == 8'h00 || $past(wr_alo)))
      else $error("single-shot timer kept its enable");
   sw_write_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
      wr_alo |=> (s_r.cnt[0] == $past(hwdata[7:0])))
      else $error("count write lost to decrementer");
   casc_high_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      (s_r.casc && s_r.en[0] && s_r.cnt[0] != 8'h00 && !wr_ahi && !wr_ctrl)
      |=> $stable(s_r.cnt[1]))
      else $error("cascaded high byte moved without low underflow");
   b_wide_dec_a: assert property (@(posedge clock) disable iff (!rst_n)
      (s_r.en[2] && b_wide != 16'h0000 && !wr_b && !wr_ctrl)
      |=> (b_wide == $past(b_wide) - 16'h0001))
      else $error("pair b wide count did not step down by one");
   b_zero_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
      zero_b_wide == $past(s_r.en[2] && b_wide == 16'h0000))
      else $error("pair b zero pulse not tied to zero count");
   pwm_toggle_a: assert property (@(posedge clock) disable iff (!rst_n)
      (s_r.casc && s_r.en[0] && a_wide == 16'h0000) |=> (pwm_out != $past(pwm_out)))
      else $error("pwm level did not toggle at cascaded zero");
   read_count_a: assert property (@(posedge clock) disable iff (!rst_n)
      (take && !hwrite && haddr[7:0] == cdt_pkg::A_LOW_CNT_OFF)
      |=> (hrdata == {24'h000000, $past(s_r.cnt[0])}) && hreadyout)
      else $error("read data does not match count");
   hw_clear_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_ctrl && !s_r.casc && s_r.en[0] && !s_r.rl[0] && s_r.cnt[0] == 8'h00) |=> !s_r.en[0])
      else $error("ctrl write revived a stopping timer");
endmodule // cdt_timers

// File: testbench/cdt_timers_bench.sv
// self-checking bench for the cascadable down-timer block
`timescale 1ns/100ps
module cdt_timers_bench;
   // ----------------------------------------------------------------
   // clock, reset, bus and result signals
   // ----------------------------------------------------------------
   logic clock = 1'b0; // 25 MHz system clock
   logic rst_n = 1'b0; // held low for the first two cycles
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2; // whole words only
   logic [31:0] hwdata = 32'h0;
   logic hready; // single slave: its ready is the bus ready
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic zero_a_low;
   logic zero_a_high;
   logic zero_b_wide;
   logic pwm_out;
   logic [2:0] zv; // zero pulses, indexed a low, a high, b wide
   int num_errors = 0;
   int checks_done = 0;
   // one register write and the word that reads back
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cdt_row_t;
   // registers carry their defined bits only
   // upper bits are dropped, status and unmapped places ignore writes
   cdt_row_t rows [12] = '{
      '{cdt_pkg::A_LOW_RLD_OFF, 32'hFFFFFF5A, 32'h5A},
      '{cdt_pkg::A_LOW_CNT_OFF, 32'hA5, 32'hA5},
      '{cdt_pkg::A_HIGH_RLD_OFF, 32'h3C, 32'h3C},
      '{cdt_pkg::A_HIGH_CNT_OFF, 32'hC3, 32'hC3},
      '{cdt_pkg::B_LOW_RLD_OFF, 32'h81, 32'h81},
      '{cdt_pkg::B_LOW_CNT_OFF, 32'h7E, 32'h7E},
      '{cdt_pkg::B_HIGH_RLD_OFF, 32'hFF, 32'hFF},
      '{cdt_pkg::B_HIGH_CNT_OFF, 32'h01, 32'h01},
      '{cdt_pkg::CTRL_OFF, 32'hFFFFFE70, 32'h070},
      '{cdt_pkg::STAT_OFF, 32'h0F, 32'h0},
      '{8'h28, 32'h55, 32'h0},
      '{cdt_pkg::CTRL_OFF, 32'h0, 32'h0}};

   assign hready = hreadyout;
   assign zv = {zero_b_wide, zero_a_high, zero_a_low};

   // free-running clock, 40 ns period
   always #20 clock = ~clock;

   cdt_timers dut
   (
      .clock(clock),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .zero_a_low(zero_a_low),
      .zero_a_high(zero_a_high),
      .zero_b_wide(zero_b_wide),
      .pwm_out(pwm_out)
   );

   // ----------------------------------------------------------------
   // helper tasks
   // ----------------------------------------------------------------
   // compare and count; x or z never passes
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
         num_errors++;
      end
   endtask

   // one single transfer; entered just after a rising edge, ends on the data edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, e);
   endtask

   // counts edges until the chosen zero pulse is seen; the bound keeps a dead timer finite
   task automatic gap(input logic [1:0] sel, input logic [31:0] exp, input logic chk);
      int n;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (zv[sel] !== 1'b1 && n < 3000);
      if (chk)
         check(32'(n), exp);
   endtask

   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // watchdog: the whole run needs about 950 cycles
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      conclude();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      // register table: write then read back every row
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      // single-shot pair a low from 3: zero pulse five edges after enabling
      wr(cdt_pkg::A_LOW_CNT_OFF, 32'h3);
      wr(cdt_pkg::CTRL_OFF, 32'h001);
      gap(2'h0, 32'h5, 1'b1);
      @(posedge clock);
      check({31'h0, zero_a_low}, 32'h0);
      rd_chk(cdt_pkg::STAT_OFF, 32'h0);
      rd_chk(cdt_pkg::A_LOW_CNT_OFF, 32'h0);
      // enable rewritten on the very edge that single-shot clears it
      wr(cdt_pkg::A_LOW_CNT_OFF, 32'h3);
      wr(cdt_pkg::CTRL_OFF, 32'h001);
      repeat (2) @(posedge clock);
      wr(cdt_pkg::CTRL_OFF, 32'h001);
      rd_chk(cdt_pkg::STAT_OFF, 32'h0);
      // pair a high in reload mode, reload and count changed while running
      wr(cdt_pkg::A_HIGH_RLD_OFF, 32'h3);
      wr(cdt_pkg::A_HIGH_CNT_OFF, 32'h1);
      wr(cdt_pkg::CTRL_OFF, 32'h022);
      gap(2'h1, 32'h0, 1'b0);
      gap(2'h1, 32'h4, 1'b1);
      // reload lands an edge before the copy
      wr(cdt_pkg::A_HIGH_RLD_OFF, 32'h5);
      gap(2'h1, 32'h0, 1'b0);
      gap(2'h1, 32'h6, 1'b1);
      // count write on a decrement edge, never at zero
      wr(cdt_pkg::A_HIGH_CNT_OFF, 32'h7);
      gap(2'h1, 32'h9, 1'b1);
      wr(cdt_pkg::CTRL_OFF, 32'h0);
      // pair a cascaded: {high,low} = 0x0103, then reload 0x0002
      wr(cdt_pkg::A_LOW_CNT_OFF, 32'h3);
      wr(cdt_pkg::A_HIGH_CNT_OFF, 32'h1);
      wr(cdt_pkg::A_LOW_RLD_OFF, 32'h2);
      wr(cdt_pkg::A_HIGH_RLD_OFF, 32'h0);
      wr(cdt_pkg::CTRL_OFF, 32'h111);
      gap(2'h0, 32'h105, 1'b1);
      check({31'h0, pwm_out}, 32'h1);
      gap(2'h0, 32'h3, 1'b1);
      check({31'h0, pwm_out}, 32'h0);
      gap(2'h0, 32'h3, 1'b1);
      wr(cdt_pkg::CTRL_OFF, 32'h0);
      // pair b wide: {high,low} = 0x0200, a read in flight must not disturb it
      wr(cdt_pkg::B_LOW_CNT_OFF, 32'h0);
      wr(cdt_pkg::B_HIGH_CNT_OFF, 32'h2);
      wr(cdt_pkg::CTRL_OFF, 32'h004);
      rd_chk(cdt_pkg::B_HIGH_RLD_OFF, 32'hFF);
      gap(2'h2, 32'h200, 1'b1);
      // the pair a stop landed on a cascaded zero, which toggled the level back to 0
      rd_chk(cdt_pkg::STAT_OFF, 32'h0);
      // pair a low in reload mode from 2, reload value 2: period of three edges
      wr(cdt_pkg::A_LOW_CNT_OFF, 32'h2);
      wr(cdt_pkg::CTRL_OFF, 32'h011);
      gap(2'h0, 32'h4, 1'b1);
      gap(2'h0, 32'h3, 1'b1);
      // pair b in reload mode with reload 1 from a zero count: pulse every second edge
      wr(cdt_pkg::B_LOW_RLD_OFF, 32'h1);
      wr(cdt_pkg::B_HIGH_RLD_OFF, 32'h0);
      wr(cdt_pkg::CTRL_OFF, 32'h044);
      gap(2'h2, 32'h2, 1'b1);
      gap(2'h2, 32'h2, 1'b1);
      wr(cdt_pkg::CTRL_OFF, 32'h0);
      // reset in mid-run clears everything, pwm level included
      wr(cdt_pkg::B_HIGH_CNT_OFF, 32'h1);
      wr(cdt_pkg::CTRL_OFF, 32'h004);
      rst_n <= 1'b0;
      @(posedge clock);
      check({hreadyout, hresp, pwm_out, zv}, 32'h20);
      check(hrdata, 32'h0);
      rst_n <= 1'b1;
      @(posedge clock);
      rd_chk(cdt_pkg::CTRL_OFF, 32'h0);
      rd_chk(cdt_pkg::B_HIGH_CNT_OFF, 32'h0);
      conclude();
   end
endmodule // cdt_timers_bench
